// *** hdl/pp_skip_consts.vh ***
`ifndef PP_SKIP_CONSTS_VH
`define PP_SKIP_CONSTS_VH
// Waveform mode encodings on mode_i
`define MODE_OFF 3'h0
`define MODE_PUSH_PULL 3'h1
`define MODE_PP_COMPL 3'h2
`define MODE_PP_BRIDGE4 3'h3
`define MODE_PP_BRIDGE6 3'h4
`define MODE_PULSE_SKIP 3'h5
// Output bit positions in the six-bit output vector
`define OUT_A 0
`define OUT_B 1
`define OUT_C 2
`define OUT_D 3
`define OUT_E 4
`define OUT_F 5
// Reset values and dead-band counter width
`define DB_CNT_RESET 8'h00
`define OUT_RESET 6'h00
`define DB_WIDTH 8
`endif

// *** hdl/dead_band_timer.v ***
`timescale 1ns/1ps
// Counts one dead-band interval; busy_o is high while it runs.
module dead_band_timer #(
  parameter WIDTH = 8
) (
  input wire clock_i,
  input wire rst_i,
  input wire start_i,
  input wire [WIDTH-1:0] length_i,
  output wire busy_o,
  output wire done_o
);
  reg [WIDTH-1:0] count_q;
  reg busy_q;
  wire expire;
  assign expire = busy_q && (count_q == {WIDTH{1'b0}});
  assign busy_o = busy_q;
  assign done_o = expire;
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_q <= {WIDTH{1'b0}};
      busy_q <= 1'b0;
    end
    else if (start_i)
    begin
      // A new event restarts the interval; zero length still costs one cycle
      count_q <= (length_i == {WIDTH{1'b0}}) ? {WIDTH{1'b0}} :
        length_i - {{(WIDTH-1){1'b0}}, 1'b1};
      busy_q <= 1'b1;
    end
    else if (expire)
      busy_q <= 1'b0;
    else if (busy_q)
      count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
  end
endmodule

// *** hdl/push_pull_pulse_skip.v ***
`timescale 1ns/1ps
`include "pp_skip_consts.vh"
module push_pull_pulse_skip #(
  parameter DB_WIDTH = `DB_WIDTH
) (
  input wire clock_i,
  input wire rst_i,
  input wire enable_i,
  input wire [2:0] mode_i,
  input wire period_event_i,
  input wire rise_event_i,
  input wire fall_event_i,
  input wire rise_source_i,
  input wire db_rise_en_i,
  input wire db_fall_en_i,
  input wire [DB_WIDTH-1:0] db_rise_len_i,
  input wire [DB_WIDTH-1:0] db_fall_len_i,
  input wire [5:0] polarity_i,
  output wire pwm_out_a_o,
  output wire pwm_out_b_o,
  output wire pwm_out_c_o,
  output wire pwm_out_d_o,
  output wire pwm_out_e_o,
  output wire pwm_out_f_o,
  output wire odd_period_o
);
  // Dead-band sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_DB_RISE = 3'b010;
  localparam ST_DB_FALL = 3'b100;

  // Asynchronous source is synchronised before use
  reg src_meta_q;
  reg src_sync_q;
  reg [5:0] out_q;
  reg [5:0] pin_q;
  reg [5:0] out_d;
  reg odd_q;
  reg odd_d;
  reg was_en_q;
  reg qualified_q;
  reg qualified_d;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg pend_even_q;
  reg pend_even_d;
  reg db_start;
  reg [DB_WIDTH-1:0] db_len;
  wire db_done;
  wire compl_mode;
  wire [5:0] prim_even;
  wire [5:0] prim_odd;

  assign compl_mode = (mode_i == `MODE_PP_COMPL) ||
    (mode_i == `MODE_PP_BRIDGE6);
  // Primary outputs per parity; six-output copies onto C and D
  assign prim_odd = (mode_i == `MODE_PP_BRIDGE6) ? 6'h05 : 6'h01;
  assign prim_even = (mode_i == `MODE_PP_BRIDGE6) ? 6'h0a : 6'h02;

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      src_meta_q <= 1'b0;
      src_sync_q <= 1'b0;
    end
    else
    begin
      src_meta_q <= rise_source_i;
      src_sync_q <= src_meta_q;
    end
  end

  dead_band_timer #(
    .WIDTH(DB_WIDTH)
  ) db_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(db_start),
    .length_i(db_len),
    .busy_o(),
    .done_o(db_done)
  );

  always @*
  begin
    out_d = out_q;
    odd_d = odd_q;
    qualified_d = qualified_q;
    state_d = state_q;
    pend_even_d = pend_even_q;
    db_start = 1'b0;
    db_len = db_rise_len_i;
    if (!enable_i || !was_en_q)
    begin
      out_d = `OUT_RESET;
      odd_d = 1'b0;
      qualified_d = 1'b0;
      state_d = ST_IDLE;
    end
    else
    begin
      // Period event flips parity; first period after enable is odd
      if (period_event_i)
      begin
        odd_d = ~odd_q;
        qualified_d = src_sync_q;
      end
      case (state_q)
        ST_DB_RISE:
        begin
          if (db_done)
          begin
            // Pending primary goes active only after expiry
            out_d = out_q | (pend_even_q ? prim_even : prim_odd);
            state_d = ST_IDLE;
          end
        end
        ST_DB_FALL:
        begin
          if (db_done)
          begin
            // Only the pending complement rises; the other leg keeps its level
            if (pend_even_q)
              out_d[`OUT_F] = 1'b1;
            else
              out_d[`OUT_E] = 1'b1;
            state_d = ST_IDLE;
          end
        end
        default:
          state_d = ST_IDLE;
      endcase
      // Events follow the parity in force at this cycle
      if (mode_i == `MODE_PUSH_PULL || mode_i == `MODE_PP_BRIDGE4)
      begin
        if (rise_event_i)
          out_d = out_q | (odd_q ? 6'h05 : 6'h0a);
        else if (fall_event_i)
          out_d = out_q & ~(odd_q ? 6'h05 : 6'h0a);
        if (mode_i == `MODE_PUSH_PULL)
          out_d = out_d & 6'h03;
        else
          out_d = out_d & 6'h0f;
      end
      else if (compl_mode)
      begin
        if (rise_event_i)
        begin
          out_d[`OUT_E] = odd_q ? 1'b0 : out_q[`OUT_E];
          out_d[`OUT_F] = odd_q ? out_q[`OUT_F] : 1'b0;
          pend_even_d = ~odd_q;
          if (db_rise_en_i)
          begin
            db_start = 1'b1;
            db_len = db_rise_len_i;
            state_d = ST_DB_RISE;
          end
          else
          begin
            out_d = out_d | (odd_q ? prim_odd : prim_even);
            state_d = ST_IDLE;
          end
        end
        else if (fall_event_i)
        begin
          out_d = out_q & ~(odd_q ? prim_odd : prim_even);
          pend_even_d = ~odd_q;
          if (db_fall_en_i)
          begin
            db_start = 1'b1;
            db_len = db_fall_len_i;
            state_d = ST_DB_FALL;
          end
          else
          begin
            out_d[`OUT_E] = odd_q ? 1'b1 : out_d[`OUT_E];
            out_d[`OUT_F] = odd_q ? out_d[`OUT_F] : 1'b1;
            state_d = ST_IDLE;
          end
        end
        if (mode_i == `MODE_PP_COMPL)
          out_d = out_d & 6'h33;
      end
      else if (mode_i == `MODE_PULSE_SKIP)
      begin
        if (rise_event_i && qualified_q)
        begin
          out_d[`OUT_A] = 1'b1;
          // A coinciding period event qualifies the next pulse afresh
          qualified_d = period_event_i ? src_sync_q : 1'b0;
        end
        if (fall_event_i)
          out_d[`OUT_A] = 1'b0;
        out_d = out_d & 6'h01;
        state_d = ST_IDLE;
      end
      else
      begin
        out_d = `OUT_RESET;
        state_d = ST_IDLE;
      end
    end
  end

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_q <= `OUT_RESET;
      pin_q <= 6'h00;
      odd_q <= 1'b0;
      was_en_q <= 1'b0;
      qualified_q <= 1'b0;
      state_q <= ST_IDLE;
      pend_even_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      // Pins register polarity so a level change never glitches
      pin_q <= out_d ^ polarity_i;
      odd_q <= odd_d;
      was_en_q <= enable_i;
      qualified_q <= qualified_d;
      state_q <= state_d;
      pend_even_q <= pend_even_d;
    end
  end

  assign pwm_out_a_o = pin_q[`OUT_A];
  assign pwm_out_b_o = pin_q[`OUT_B];
  assign pwm_out_c_o = pin_q[`OUT_C];
  assign pwm_out_d_o = pin_q[`OUT_D];
  assign pwm_out_e_o = pin_q[`OUT_E];
  assign pwm_out_f_o = pin_q[`OUT_F];
  assign odd_period_o = odd_q;
endmodule

// *** test/pp_skip_sva.sv ***
`timescale 1ns/1ps
`include "pp_skip_consts.vh"
module pp_skip_sva #(parameter DB_WIDTH = 8) (
  input logic clock_i, rst_i, enable_i,
  input logic [2:0] mode_i,
  input logic period_event_i, rise_event_i, fall_event_i, db_rise_en_i,
  input logic [DB_WIDTH-1:0] db_rise_len_i,
  input logic [5:0] polarity_i,
  input logic pwm_out_a_o, pwm_out_b_o, pwm_out_c_o,
  input logic pwm_out_d_o, pwm_out_e_o, pwm_out_f_o, odd_period_o
);
  logic was_q;
  // Logic levels: polarity only changes while disabled
  wire [5:0] lv = polarity_i ^ {pwm_out_f_o, pwm_out_e_o, pwm_out_d_o,
    pwm_out_c_o, pwm_out_b_o, pwm_out_a_o};
  wire act = enable_i & was_q;
  wire r = act & rise_event_i;
  wire odd = odd_period_o;
  wire dbr = db_rise_en_i && db_rise_len_i == 8'h02;
  always @(posedge clock_i or posedge rst_i)
    if (rst_i)
      was_q <= 1'b0;
    else
      was_q <= enable_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Both legs off through the dead band, then the pending leg on
  sequence db_swap(x, y);
    (!x && !y) [*2] ##1 y;
  endsequence
  a_push_rise: assert property (
    r && mode_i == `MODE_PUSH_PULL && odd |=> lv[0]) else $error("push A");
  a_push_pins: assert property (
    act && mode_i == `MODE_PUSH_PULL |-> lv[5:2] == 4'h0) else $error("pins");
  a_bridge_copy: assert property (
    act && mode_i == `MODE_PP_BRIDGE4 |-> lv[2] == lv[0] && lv[3] == lv[1])
    else $error("bridge copy");
  a_compl_odd: assert property (
    r && mode_i == `MODE_PP_COMPL && odd && dbr |=> db_swap(lv[4], lv[0]))
    else $error("odd swap");
  a_compl_even: assert property (
    r && mode_i == `MODE_PP_COMPL && !odd && dbr |=> db_swap(lv[5], lv[1]))
    else $error("even swap");
  a_six_odd: assert property (
    r && mode_i == `MODE_PP_BRIDGE6 && odd && !db_rise_en_i
    |=> lv[0] && lv[2] && !lv[4]) else $error("six rise");
  a_skip_pins: assert property (
    act && mode_i == `MODE_PULSE_SKIP |-> lv[5:1] == 5'h00)
    else $error("skip pins");
  a_skip_fall: assert property (
    act && fall_event_i && !rise_event_i && mode_i == `MODE_PULSE_SKIP
    |=> !lv[0]) else $error("skip fall");
  a_parity_flip: assert property (
    act && period_event_i |=> odd != $past(odd)) else $error("parity");
endmodule
bind push_pull_pulse_skip pp_skip_sva #(.DB_WIDTH(DB_WIDTH)) sva_i (
  .clock_i(clock_i), .rst_i(rst_i), .enable_i(enable_i), .mode_i(mode_i),
  .period_event_i(period_event_i), .rise_event_i(rise_event_i),
  .fall_event_i(fall_event_i), .db_rise_en_i(db_rise_en_i),
  .db_rise_len_i(db_rise_len_i), .polarity_i(polarity_i),
  .pwm_out_a_o(pwm_out_a_o), .pwm_out_b_o(pwm_out_b_o),
  .pwm_out_c_o(pwm_out_c_o), .pwm_out_d_o(pwm_out_d_o),
  .pwm_out_e_o(pwm_out_e_o), .pwm_out_f_o(pwm_out_f_o),
  .odd_period_o(odd_period_o));

// *** test/bridge_stage_model.sv ***
`timescale 1ns/1ps
// Sense comparator of the power stage; moves off the clock edge
module bridge_stage_model (
  input logic clock_i,
  input logic want_i,
  output logic sense_o
);
  initial sense_o = 1'b0;
  always @(posedge clock_i)
    sense_o <= #7 want_i;
endmodule

// *** test/push_pull_pulse_skip_tb.sv ***
`timescale 1ns/1ps
`include "pp_skip_consts.vh"
module push_pull_pulse_skip_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic en = 1'b0;
  logic dbe = 1'b0;
  logic want = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [2:0] ev = 3'h0;
  logic [7:0] dbl = 8'h02;
  logic [5:0] pol = 6'h00;
  logic src;
  wire [5:0] pins;
  wire odd;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  always #20 clock_i = ~clock_i;
  push_pull_pulse_skip dut (.clock_i(clock_i), .rst_i(rst_i),
    .enable_i(en), .mode_i(mode), .period_event_i(ev[2]),
    .rise_event_i(ev[1]), .fall_event_i(ev[0]), .rise_source_i(src),
    .db_rise_en_i(dbe), .db_fall_en_i(dbe), .db_rise_len_i(dbl),
    .db_fall_len_i(dbl), .polarity_i(pol), .pwm_out_a_o(pins[0]),
    .pwm_out_b_o(pins[1]), .pwm_out_c_o(pins[2]), .pwm_out_d_o(pins[3]),
    .pwm_out_e_o(pins[4]), .pwm_out_f_o(pins[5]), .odd_period_o(odd));
  bridge_stage_model psu (.clock_i(clock_i), .want_i(want), .sense_o(src));
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD odd_and_pins expected %h seen %h", exp, got);
    end
  endtask
  // Event pulse (none if zero), n more edges, then check parity and pins
  task automatic see(input logic [2:0] e, input int n, input logic [6:0] x);
    if (e != 3'h0)
    begin
      @(posedge clock_i) ev <= e;
      @(posedge clock_i) ev <= 3'h0;
    end
    repeat (n) @(posedge clock_i);
    #1;
    chk({odd, pins}, x);
  endtask
  // Mode, dead-band enable and polarity change only while disabled, which clears parity
  task automatic start(input logic [2:0] m, input logic d,
    input logic [5:0] p);
    @(posedge clock_i) en <= 1'b0;
    repeat (2) @(posedge clock_i);
    mode <= m;
    dbe <= d;
    pol <= p;
    en <= 1'b1;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic t_push;
    start(`MODE_PUSH_PULL, 1'b1, 6'h00);
    see(3'h4, 0, 7'h40);
    see(3'h2, 0, 7'h41);
    see(3'h1, 0, 7'h40);
    see(3'h4, 0, 7'h00);
    see(3'h3, 0, 7'h02);
  endtask
  task automatic t_compl;
    start(`MODE_PP_COMPL, 1'b1, 6'h00);
    see(3'h4, 0, 7'h40);
    see(3'h2, 0, 7'h40);
    see(3'h0, 2, 7'h41);
    see(3'h1, 0, 7'h40);
    see(3'h0, 2, 7'h50);
    see(3'h4, 0, 7'h10);
    see(3'h2, 0, 7'h10);
    see(3'h0, 2, 7'h12);
    see(3'h1, 0, 7'h10);
    see(3'h0, 2, 7'h30);
    see(3'h4, 0, 7'h70);
    see(3'h2, 0, 7'h60);
    see(3'h0, 2, 7'h61);
    see(3'h1, 0, 7'h60);
    see(3'h0, 2, 7'h70);
  endtask
  task automatic t_bridge;
    start(`MODE_PP_BRIDGE4, 1'b1, 6'h00);
    see(3'h4, 0, 7'h40);
    see(3'h2, 0, 7'h45);
    see(3'h1, 0, 7'h40);
    see(3'h4, 0, 7'h00);
    see(3'h2, 0, 7'h0a);
  endtask
  task automatic t_six;
    start(`MODE_PP_BRIDGE6, 1'b0, 6'h00);
    see(3'h4, 0, 7'h40);
    see(3'h2, 0, 7'h45);
    see(3'h1, 0, 7'h50);
    see(3'h4, 0, 7'h10);
    see(3'h2, 0, 7'h1a);
    see(3'h1, 0, 7'h30);
  endtask
  task automatic t_skip;
    start(`MODE_PULSE_SKIP, 1'b1, 6'h00);
    see(3'h4, 0, 7'h40);
    see(3'h2, 0, 7'h40);
    @(posedge clock_i) want <= 1'b1;
    see(3'h0, 3, 7'h40);
    see(3'h4, 0, 7'h00);
    see(3'h2, 0, 7'h01);
    see(3'h1, 0, 7'h00);
    see(3'h4, 0, 7'h40);
    see(3'h6, 0, 7'h01);
    see(3'h1, 0, 7'h00);
    see(3'h2, 0, 7'h01);
  endtask
  task automatic t_pol;
    start(`MODE_PUSH_PULL, 1'b0, 6'h3f);
    see(3'h0, 0, 7'h3f);
    see(3'h4, 0, 7'h7f);
    see(3'h2, 0, 7'h7e);
  endtask
  // Mode off keeps pins idle; zero dead band still costs one cycle
  task automatic t_zero;
    @(posedge clock_i) dbl <= 8'h00;
    start(`MODE_OFF, 1'b1, 6'h00);
    see(3'h4, 0, 7'h40);
    see(3'h2, 0, 7'h40);
    start(`MODE_PP_COMPL, 1'b1, 6'h00);
    see(3'h4, 0, 7'h40);
    see(3'h2, 0, 7'h40);
    see(3'h0, 1, 7'h41);
  endtask
  task report_and_stop;
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    t_push;
    t_compl;
    t_bridge;
    t_six;
    t_skip;
    t_pol;
    t_zero;
    report_and_stop;
  end
  // Whole run needs about 150 cycles
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      report_and_stop;
    end
  end
endmodule
